// >>> pkg/crc_if.sv
// carrier between the descriptor controller and its checksum unit
interface crc_if;
   logic        clear;
   logic        valid;
   logic [31:0] data;
   logic [31:0] crc;
   modport eng (output clear, output valid, output data, input crc);
   modport unit (input clear, input valid, input data, output crc);
endinterface

// >>> pkg/dma_desc_pkg.sv
// constants, types and register map of the dma descriptor control block
// Function
// - a descriptor is eight doublewords: control flags in DW1, checksum in DW8
// - cross-host: source END_OF_TRANSFER_FLAG from software; device sets destination END_OF_TRANSFER_FLAG, count
// - root-only with END_OF_TRANSFER_FLAG valid: set END_OF_TRANSFER_FLAG once the transfer count is exhausted
// - wide_address_select picks 64-bit addresses, else 32-bit addresses
// - source_address_valid clear: no reads, only destination side works
// - dest_address_valid clear: no writes, only source side works
// - source_domain_valid: reads go to the source domain, its sizes
// - dest_domain_valid: writes go to the destination domain, its size
// - null_descriptor: zero length, no memory reads or writes
// - cache_flush_request: cancel reads, drop descriptor, reset channel regs
// - start bit at 20h is cleared when the flush has finished
// - completion_interrupt_request raises an interrupt on completion or fail
// - interrupt flag bit 31 at 20h is cleared by writing one
// - interrupt delivered as INTx, MSI or MSI-X, whichever is enabled
// - TPH set: each write carries TH and the steering tag from DW1 7:0
// - steering tag is used only with TPH set, ignored otherwise
// - 5-bit error codes: poison 12, timeout 14, abort 15, ECRC 19, UR 20
// - simultaneous errors record the lowest code only
// - checksum enable: CRC-32 over raw data bytes read, no headers
// - checksum uses the ECRC polynomial, doubleword units
// - final checksum is written into the eighth doubleword
package dma_desc_pkg;
   localparam int DESC_DW   = 8;
   localparam int CTRL_DW   = 0;
   localparam int COUNT_DW  = 1;
   localparam int DST_HI_DW = 2;
   localparam int DST_LO_DW = 3;
   localparam int SRC_HI_DW = 4;
   localparam int SRC_LO_DW = 5;
   localparam int DOM_DW    = 6;
   localparam int CRC_DW    = 7;
   // control word bits
   localparam int EOT_BIT   = 31;
   localparam int INT_BIT   = 30;
   localparam int TPH_BIT   = 29;
   localparam int NULL_BIT  = 28;
   localparam int FLUSH_BIT = 27;
   localparam int SAV_BIT   = 26;
   localparam int DAV_BIT   = 25;
   localparam int WIDE_BIT  = 24;
   localparam int SDV_BIT   = 23;
   localparam int DDV_BIT   = 22;
   localparam int CRC_BIT   = 21;
   localparam int ERR_LSB   = 8;
   localparam int ERR_W     = 5;
   localparam int ST_W      = 8;
   localparam int COUNT_W   = 23;
   localparam int DOM_W     = 4;
   localparam int SRC_DOM_LSB = 8;
   localparam logic [COUNT_W-1:0] DW_BYTES = 23'h000004;
   // error codes and error input positions
   localparam logic [ERR_W-1:0] ERR_NONE   = 5'h00;
   localparam logic [ERR_W-1:0] ERR_POISON = 5'h0c;
   localparam logic [ERR_W-1:0] ERR_CTO    = 5'h0e;
   localparam logic [ERR_W-1:0] ERR_CA     = 5'h0f;
   localparam logic [ERR_W-1:0] ERR_ECRC   = 5'h13;
   localparam logic [ERR_W-1:0] ERR_UR     = 5'h14;
   localparam int EI_POISON = 0;
   localparam int EI_CTO    = 1;
   localparam int EI_CA     = 2;
   localparam int EI_ECRC   = 3;
   localparam int EI_UR     = 4;
   // register map
   localparam logic [7:0] MODE_OFS  = 8'h00;
   localparam logic [7:0] IRQEN_OFS = 8'h04;
   localparam logic [7:0] STAT_OFS  = 8'h08;
   localparam logic [7:0] CHAN_OFS  = 8'h20;
   localparam int START_BIT   = 0;
   localparam int IFLAG_BIT   = 31;
   localparam int ROOT_BIT    = 0;
   localparam int EOTV_BIT    = 1;
   localparam int INTX_EN_BIT = 0;
   localparam int MSI_EN_BIT  = 1;
   localparam int MSIX_EN_BIT = 2;
   localparam logic [1:0] MODE_RST  = 2'h0;
   localparam logic [2:0] IRQEN_RST = 3'h0;
   // checksum
   localparam logic [31:0] CRC_POLY = 32'h04c11db7;
   localparam logic [31:0] CRC_INIT = 32'hffffffff;
   typedef enum logic [2:0] {
      S_IDLE, S_ISSUE, S_MOVE, S_FINAL, S_BACK, S_FLUSH
   } state_t;
endpackage

// >>> rtl/crc32_dw.sv
// crc-32 over whole doublewords, ecrc polynomial
module crc32_dw
   import dma_desc_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic rst_i,
   crc_if.unit       c
);
   logic [31:0] crc_q;
   logic [31:0] crc_d;

   function automatic logic [31:0] step(input logic [31:0] cur,
                                        input logic [31:0] dw);
      logic [31:0] r;
      r = cur;
      for (int i = 31; i >= 0; i--) begin
         if (r[31] ^ dw[i]) begin
            r = {r[30:0], 1'b0} ^ CRC_POLY;
         end else begin
            r = {r[30:0], 1'b0};
         end
      end
      return r;
   endfunction

   always_comb begin
      crc_d = crc_q;
      if (c.clear) begin
         crc_d = CRC_INIT;
      end else if (c.valid) begin
         crc_d = step(crc_q, c.data);
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         crc_q <= CRC_INIT;
      end else begin
         crc_q <= crc_d;
      end
   end

   assign c.crc = ~crc_q;
endmodule

// >>> rtl/dma_desc_ctrl.sv
// descriptor control word interpreter with wishbone channel registers
//
// Chosen here: the Wishbone interface to the registers and the register addresses.
module dma_desc_ctrl
   import dma_desc_pkg::*;
#(
   parameter int ADR_W = 8
)(
   input  wire logic                     clk_i,
   input  wire logic                     rst_i,
   input  wire logic                     wb_cyc_i,
   input  wire logic                     wb_stb_i,
   input  wire logic                     wb_we_i,
   input  wire logic [ADR_W-1:0]         wb_adr_i,
   input  wire logic [3:0]               wb_sel_i,
   input  wire logic [31:0]              wb_dat_i,
   output logic      [31:0]              wb_dat_o,
   output logic                          wb_ack_o,
   input  wire logic                     desc_valid_i,
   output logic                          desc_ready_o,
   input  wire logic [DESC_DW-1:0][31:0] desc_i,
   output logic                          rd_req_valid_o,
   input  wire logic                     rd_req_ready_i,
   output logic      [63:0]              rd_addr_o,
   output logic                          rd_dom_sel_o,
   output logic      [DOM_W-1:0]         rd_domain_o,
   output logic                          wr_req_valid_o,
   input  wire logic                     wr_req_ready_i,
   output logic      [63:0]              wr_addr_o,
   output logic                          wr_dom_sel_o,
   output logic      [DOM_W-1:0]         wr_domain_o,
   output logic                          wr_th_o,
   output logic      [ST_W-1:0]          wr_st_o,
   input  wire logic                     data_valid_i,
   input  wire logic [31:0]              data_i,
   input  wire logic [4:0]               err_i,
   input  wire logic                     peer_eot_i,
   output logic                          peer_eot_o,
   output logic                          flush_o,
   input  wire logic                     flush_ack_i,
   output logic                          back_valid_o,
   input  wire logic                     back_ready_i,
   output logic      [DESC_DW-1:0][31:0] back_desc_o,
   output logic                          intx_o,
   output logic                          msi_o,
   output logic                          msix_o
);
   crc_if c ();

   crc32_dw u_crc (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .c     (c.unit)
   );

   // descriptor processing state
   state_t                     state_q;
   state_t                     state_d;
   logic [DESC_DW-1:0][31:0]   desc_q;
   logic [DESC_DW-1:0][31:0]   desc_d;
   logic [COUNT_W-1:0]         rem_q;
   logic [COUNT_W-1:0]         rem_d;
   logic [COUNT_W-1:0]         moved_q;
   logic [COUNT_W-1:0]         moved_d;
   logic                       rd_sent_q;
   logic                       rd_sent_d;
   logic                       wr_sent_q;
   logic                       wr_sent_d;
   logic                       eot_seen_q;
   logic                       eot_seen_d;
   logic [ERR_W-1:0]           err_q;
   logic [ERR_W-1:0]           err_d;
   logic [63:0]                rd_addr_q;
   logic [63:0]                rd_addr_d;
   logic [63:0]                wr_addr_q;
   logic [63:0]                wr_addr_d;
   logic [DOM_W-1:0]           rd_dom_q;
   logic [DOM_W-1:0]           rd_dom_d;
   logic [DOM_W-1:0]           wr_dom_q;
   logic [DOM_W-1:0]           wr_dom_d;
   logic [ST_W-1:0]            st_q;
   logic [ST_W-1:0]            st_d;

   // channel register state
   logic [1:0]                 mode_q;
   logic [1:0]                 mode_d;
   logic [2:0]                 irqen_q;
   logic [2:0]                 irqen_d;
   logic                       start_q;
   logic                       start_d;
   logic                       iflag_q;
   logic                       iflag_d;
   logic                       ack_q;
   logic                       ack_d;
   logic [31:0]                rdat_q;
   logic [31:0]                rdat_d;
   logic                       msi_q;
   logic                       msi_d;
   logic                       msix_q;
   logic                       msix_d;

   logic [31:0]                ctrl;
   logic                       desc_take;
   logic                       rd_take;
   logic                       wr_take;
   logic                       back_take;
   logic                       irq_evt;
   logic                       flush_done;
   logic                       err_any;
   logic [ERR_W-1:0]           err_pick;
   logic                       wb_req;
   logic                       wb_wr;
   logic [7:0]                 reg_ofs;

   assign ctrl       = desc_q[CTRL_DW];
   assign desc_ready_o = (state_q == S_IDLE) && start_q;
   assign desc_take  = desc_valid_i && desc_ready_o;
   assign rd_take    = rd_req_valid_o && rd_req_ready_i;
   assign wr_take    = wr_req_valid_o && wr_req_ready_i;
   assign back_take  = back_valid_o && back_ready_i;
   assign flush_done = (state_q == S_FLUSH) && flush_ack_i;
   assign err_any    = |err_i;
   assign irq_evt    = back_take && ctrl[INT_BIT];

   // lowest code wins when several errors land together
   always_comb begin
      if (err_i[EI_POISON]) begin
         err_pick = ERR_POISON;
      end else if (err_i[EI_CTO]) begin
         err_pick = ERR_CTO;
      end else if (err_i[EI_CA]) begin
         err_pick = ERR_CA;
      end else if (err_i[EI_ECRC]) begin
         err_pick = ERR_ECRC;
      end else if (err_i[EI_UR]) begin
         err_pick = ERR_UR;
      end else begin
         err_pick = ERR_NONE;
      end
   end

   // only raw payload doublewords reach the checksum
   assign c.clear = desc_take;
   assign c.valid = (state_q == S_MOVE) && data_valid_i
                    && ctrl[CRC_BIT] && !err_any;
   assign c.data  = data_i;

   always_comb begin
      state_d    = state_q;
      desc_d     = desc_q;
      rem_d      = rem_q;
      moved_d    = moved_q;
      rd_sent_d  = rd_sent_q;
      wr_sent_d  = wr_sent_q;
      eot_seen_d = eot_seen_q;
      err_d      = err_q;
      rd_addr_d  = rd_addr_q;
      wr_addr_d  = wr_addr_q;
      rd_dom_d   = rd_dom_q;
      wr_dom_d   = wr_dom_q;
      st_d       = st_q;
      unique case (state_q)
         S_IDLE: begin
            if (desc_take) begin
               desc_d     = desc_i;
               rem_d      = desc_i[COUNT_DW][COUNT_W-1:0];
               moved_d    = '0;
               rd_sent_d  = 1'b0;
               wr_sent_d  = 1'b0;
               eot_seen_d = 1'b0;
               err_d      = ERR_NONE;
               if (desc_i[CTRL_DW][WIDE_BIT]) begin
                  rd_addr_d = {desc_i[SRC_HI_DW], desc_i[SRC_LO_DW]};
                  wr_addr_d = {desc_i[DST_HI_DW], desc_i[DST_LO_DW]};
               end else begin
                  rd_addr_d = {32'h0, desc_i[SRC_LO_DW]};
                  wr_addr_d = {32'h0, desc_i[DST_LO_DW]};
               end
               rd_dom_d = desc_i[CTRL_DW][SDV_BIT]
                  ? desc_i[DOM_DW][SRC_DOM_LSB +: DOM_W] : '0;
               wr_dom_d = desc_i[CTRL_DW][DDV_BIT]
                  ? desc_i[DOM_DW][DOM_W-1:0] : '0;
               st_d = desc_i[CTRL_DW][TPH_BIT]
                  ? desc_i[CTRL_DW][ST_W-1:0] : '0;
               if (desc_i[CTRL_DW][FLUSH_BIT]) begin
                  state_d = S_FLUSH;
               end else if (desc_i[CTRL_DW][NULL_BIT]) begin
                  state_d = S_FINAL;
               end else begin
                  state_d = S_ISSUE;
               end
            end
         end
         S_ISSUE: begin
            if (rd_take) begin
               rd_sent_d = 1'b1;
            end
            if (wr_take) begin
               wr_sent_d = 1'b1;
            end
            if (err_any) begin
               err_d   = err_pick;
               state_d = S_FINAL;
            end else if ((rd_sent_q || rd_take || !ctrl[SAV_BIT])
                      && (wr_sent_q || wr_take || !ctrl[DAV_BIT])) begin
               state_d = S_MOVE;
            end
         end
         S_MOVE: begin
            if (err_any) begin
               err_d   = err_pick;
               state_d = S_FINAL;
            end else if (peer_eot_i && !mode_q[ROOT_BIT]) begin
               eot_seen_d = 1'b1;
               state_d    = S_FINAL;
            end else if (rem_q == '0) begin
               state_d = S_FINAL;
            end else if (data_valid_i) begin
               if (rem_q > DW_BYTES) begin
                  rem_d   = rem_q - DW_BYTES;
                  moved_d = moved_q + DW_BYTES;
               end else begin
                  rem_d   = '0;
                  moved_d = moved_q + rem_q;
               end
            end
         end
         S_FINAL: begin
            desc_d[CTRL_DW][ERR_LSB +: ERR_W] = err_q;
            if (!mode_q[ROOT_BIT]) begin
               if (eot_seen_q) begin
                  desc_d[CTRL_DW][EOT_BIT] = 1'b1;
                  desc_d[COUNT_DW][COUNT_W-1:0] = moved_q;
               end
            end else if (mode_q[EOTV_BIT] && err_q == ERR_NONE
                         && !ctrl[NULL_BIT]) begin
               desc_d[CTRL_DW][EOT_BIT] = 1'b1;
            end
            if (ctrl[CRC_BIT]) begin
               desc_d[CRC_DW] = c.crc;
            end
            state_d = S_BACK;
         end
         S_BACK: begin
            if (back_ready_i) begin
               state_d = S_IDLE;
            end
         end
         S_FLUSH: begin
            if (flush_ack_i) begin
               state_d = S_IDLE;
            end
         end
         default: begin
            state_d = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q    <= S_IDLE;
         desc_q     <= '0;
         rem_q      <= '0;
         moved_q    <= '0;
         rd_sent_q  <= 1'b0;
         wr_sent_q  <= 1'b0;
         eot_seen_q <= 1'b0;
         err_q      <= ERR_NONE;
         rd_addr_q  <= '0;
         wr_addr_q  <= '0;
         rd_dom_q   <= '0;
         wr_dom_q   <= '0;
         st_q       <= '0;
      end else begin
         state_q    <= state_d;
         desc_q     <= desc_d;
         rem_q      <= rem_d;
         moved_q    <= moved_d;
         rd_sent_q  <= rd_sent_d;
         wr_sent_q  <= wr_sent_d;
         eot_seen_q <= eot_seen_d;
         err_q      <= err_d;
         rd_addr_q  <= rd_addr_d;
         wr_addr_q  <= wr_addr_d;
         rd_dom_q   <= rd_dom_d;
         wr_dom_q   <= wr_dom_d;
         st_q       <= st_d;
      end
   end

   assign rd_req_valid_o = (state_q == S_ISSUE) && ctrl[SAV_BIT]
                           && !rd_sent_q;
   assign wr_req_valid_o = (state_q == S_ISSUE) && ctrl[DAV_BIT]
                           && !wr_sent_q;
   assign rd_addr_o    = rd_addr_q;
   assign rd_dom_sel_o = ctrl[SDV_BIT];
   assign rd_domain_o  = rd_dom_q;
   assign wr_addr_o    = wr_addr_q;
   assign wr_dom_sel_o = ctrl[DDV_BIT];
   assign wr_domain_o  = wr_dom_q;
   assign wr_th_o      = ctrl[TPH_BIT];
   assign wr_st_o      = st_q;
   assign flush_o      = (state_q == S_FLUSH);
   assign back_valid_o = (state_q == S_BACK);
   assign back_desc_o  = desc_q;
   // tells the destination end that the source sent its last transfer
   assign peer_eot_o   = back_take && !mode_q[ROOT_BIT]
                         && ctrl[SAV_BIT] && ctrl[EOT_BIT];

   // wishbone slave: writes land on the edge that ends ack
   assign wb_req  = wb_cyc_i && wb_stb_i;
   assign wb_wr   = wb_req && wb_we_i && ack_q;
   assign reg_ofs = 8'(wb_adr_i);

   always_comb begin
      mode_d  = mode_q;
      irqen_d = irqen_q;
      start_d = start_q;
      iflag_d = iflag_q;
      ack_d   = wb_req && !ack_q;
      rdat_d  = rdat_q;
      msi_d   = 1'b0;
      msix_d  = 1'b0;
      if (wb_req && !ack_q) begin
         unique case (reg_ofs)
            MODE_OFS:  rdat_d = {30'h0, mode_q};
            IRQEN_OFS: rdat_d = {29'h0, irqen_q};
            STAT_OFS:  rdat_d = {26'h0, state_q != S_IDLE, err_q};
            CHAN_OFS:  rdat_d = {iflag_q, 30'h0, start_q};
            default:   rdat_d = 32'h0;
         endcase
      end
      if (wb_wr && wb_sel_i[0]) begin
         if (reg_ofs == MODE_OFS) begin
            mode_d = wb_dat_i[1:0];
         end
         if (reg_ofs == IRQEN_OFS) begin
            irqen_d = wb_dat_i[2:0];
         end
         if (reg_ofs == CHAN_OFS) begin
            start_d = wb_dat_i[START_BIT];
         end
      end
      if (wb_wr && wb_sel_i[3] && reg_ofs == CHAN_OFS
          && wb_dat_i[IFLAG_BIT]) begin
         iflag_d = 1'b0;
      end
      if (irq_evt) begin
         iflag_d = 1'b1;
         if (irqen_q[MSIX_EN_BIT]) begin
            msix_d = 1'b1;
         end else if (irqen_q[MSI_EN_BIT]) begin
            msi_d = 1'b1;
         end
      end
      if (flush_done) begin
         mode_d  = MODE_RST;
         irqen_d = IRQEN_RST;
         start_d = 1'b0;
         iflag_d = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_q  <= MODE_RST;
         irqen_q <= IRQEN_RST;
         start_q <= 1'b0;
         iflag_q <= 1'b0;
         ack_q   <= 1'b0;
         rdat_q  <= 32'h0;
         msi_q   <= 1'b0;
         msix_q  <= 1'b0;
      end else begin
         mode_q  <= mode_d;
         irqen_q <= irqen_d;
         start_q <= start_d;
         iflag_q <= iflag_d;
         ack_q   <= ack_d;
         rdat_q  <= rdat_d;
         msi_q   <= msi_d;
         msix_q  <= msix_d;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;
   assign msi_o    = msi_q;
   assign msix_o   = msix_q;
   // legacy line only when no message mechanism is enabled
   assign intx_o   = iflag_q && irqen_q[INTX_EN_BIT]
                     && !irqen_q[MSI_EN_BIT] && !irqen_q[MSIX_EN_BIT];

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   null_no_req_a: assert property (
      (desc_take && desc_i[CTRL_DW][NULL_BIT]
       && !desc_i[CTRL_DW][FLUSH_BIT])
      |=> (!rd_req_valid_o && !wr_req_valid_o)[*2] ##0 back_valid_o)
      else $error("null descriptor issued a request");
   src_gate_a: assert property (
      rd_req_valid_o |-> ctrl[SAV_BIT] && rd_domain_o ==
      (ctrl[SDV_BIT] ? desc_q[DOM_DW][SRC_DOM_LSB +: DOM_W] : 4'h0))
      else $error("read without valid source");
   dst_gate_a: assert property (
      wr_req_valid_o |-> ctrl[DAV_BIT] && wr_domain_o ==
      (ctrl[DDV_BIT] ? desc_q[DOM_DW][DOM_W-1:0] : 4'h0))
      else $error("write without valid destination");
   tph_tag_a: assert property (
      wr_req_valid_o |-> wr_th_o == ctrl[TPH_BIT] && wr_st_o ==
      (ctrl[TPH_BIT] ? ctrl[ST_W-1:0] : 8'h00))
      else $error("steering tag mismatch");
   narrow_addr_a: assert property (
      (rd_req_valid_o && !ctrl[WIDE_BIT]) |-> rd_addr_o[63:32] == 32'h0)
      else $error("high address used in 32-bit mode");
   err_lowest_a: assert property (
      ((state_q == S_ISSUE || state_q == S_MOVE) && err_i[EI_POISON])
      |-> ##2 back_valid_o && back_desc_o[CTRL_DW][ERR_LSB +: ERR_W]
          == ERR_POISON)
      else $error("error code not the lowest");
   irq_raise_a: assert property (
      irq_evt |=> iflag_q ##0 (msix_q == $past(irqen_q[MSIX_EN_BIT])))
      else $error("interrupt not raised on completion");
   flush_start_a: assert property (
      flush_done |=> !start_q && mode_q == MODE_RST && state_q == S_IDLE)
      else $error("flush did not clear start");
   root_eot_a: assert property (
      (state_q == S_FINAL && mode_q == 2'h3 && err_q == ERR_NONE
       && !ctrl[NULL_BIT]) |=> back_desc_o[CTRL_DW][EOT_BIT])
      else $error("end of transfer not marked");
endmodule

// >>> verif/hostmem_model.sv
// host memory side: request readiness, read data beats, writeback taking
module hostmem_model (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        slow_i,
   input  wire logic [3:0]  beats_i,
   input  wire logic        rd_req_valid_i,
   input  wire logic        wr_req_valid_i,
   input  wire logic        back_valid_i,
   output logic             rd_req_ready_o,
   output logic             wr_req_ready_o,
   output logic             back_ready_o,
   output logic             data_valid_o,
   output logic      [31:0] data_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0]  left_q;
   logic        tick_q;
   logic        go;
   logic [31:0] word;
   // slow mode answers on every other cycle only
   assign go = tick_q | !slow_i;
   assign rd_req_ready_o = rd_req_valid_i & go;
   assign wr_req_ready_o = wr_req_valid_i & go;
   assign back_ready_o = back_valid_i & go;
   assign data_valid_o = (left_q != 4'h0) & go;
   assign word = {28'hda7a000, left_q};
   // released data lines show the inverse pattern
   assign data_o = data_valid_o ? word : ~word;
   always_ff @(posedge clk_i) begin
      tick_q <= rst_i ? 1'b0 : !tick_q;
      if (rst_i)
         left_q <= 4'h0;
      else if (rd_req_valid_i & rd_req_ready_o)
         left_q <= beats_i;
      else if (data_valid_o)
         left_q <= left_q - 4'h1;
   end
endmodule

// >>> verif/testbench.sv
// self-checking bench for the descriptor control block
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
   n_errors++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import dma_desc_pkg::*;
   logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, desc_valid_i;
   logic        rd_req_ready_i, wr_req_ready_i, data_valid_i, peer_eot_i;
   logic        flush_ack_i, back_ready_i, wb_ack_o, desc_ready_o, slow;
   logic        rd_req_valid_o, rd_dom_sel_o, wr_req_valid_o, wr_dom_sel_o;
   logic        wr_th_o, peer_eot_o, flush_o, back_valid_o, intx_o, msi_o;
   logic        msix_o, pe;
   logic [3:0]  wb_sel_i, rd_domain_o, wr_domain_o;
   logic [4:0]  err_i;
   logic [7:0]  wb_adr_i, wr_st_o;
   logic [31:0] wb_dat_i, wb_dat_o, data_i, seed;
   logic [63:0] rd_addr_o, wr_addr_o;
   logic [DESC_DW-1:0][31:0] desc_i, back_desc_o, d;
   logic [68:0] exp_rd[$];
   logic [77:0] exp_wr[$];
   logic [38:0] exp_back[$];
   logic [31:0] exp_wb[$];
   int          n_errors, checks_done, n_msi;
   dma_desc_ctrl dma_desc_ctrl_i (.*);
   hostmem_model hostmem_model_i (.clk_i, .rst_i, .slow_i(slow),
      .beats_i(4'h2), .rd_req_valid_i(rd_req_valid_o),
      .wr_req_valid_i(wr_req_valid_o), .back_valid_i(back_valid_o),
      .rd_req_ready_o(rd_req_ready_i), .wr_req_ready_o(wr_req_ready_i),
      .back_ready_o(back_ready_i), .data_valid_o(data_valid_i),
      .data_o(data_i));
   wire [38:0] back_seen = {peer_eot_o, back_desc_o[CTRL_DW][EOT_BIT],
      back_desc_o[CTRL_DW][ERR_LSB+:ERR_W], back_desc_o[CRC_DW]};
   wire [77:0] wr_seen = {wr_th_o, wr_st_o, wr_dom_sel_o, wr_domain_o,
      wr_addr_o};
   // destination end hears of the source's last transfer after its write
   always @(posedge clk_i)
      peer_eot_i <= pe & wr_req_valid_o & wr_req_ready_i;
   always #2.5 clk_i = ~clk_i;
   always @(posedge clk_i) begin : mon
      logic [77:0] e;
      if (msi_o)
         n_msi++;
      if (wb_ack_o && !wb_we_i) begin
         e = 78'(exp_wb.pop_front());
         `CHK("wb_dat_o", e[31:0], wb_dat_o)
      end
      if (rd_req_valid_o && rd_req_ready_i) begin
         e = 78'(exp_rd.pop_front());
         `CHK("rd", e[68:0], {rd_dom_sel_o, rd_domain_o, rd_addr_o})
      end
      if (wr_req_valid_o && wr_req_ready_i) begin
         e = exp_wr.pop_front();
         `CHK("wr", e, wr_seen)
      end
      if (back_valid_o && back_ready_i) begin
         e = 78'(exp_back.pop_front());
         `CHK("back", e[38:0], back_seen)
      end
   end
   function automatic logic [31:0] crc_of(input int n);
      logic [31:0] c;
      logic [31:0] w;
      c = CRC_INIT;
      for (int k = n; k > 0; k--) begin
         w = 32'hda7a0000 + k;
         for (int b = 31; b >= 0; b--)
            c = {c[30:0], 1'b0} ^ ((c[31] ^ w[b]) ? CRC_POLY : 32'h0);
      end
      return ~c;
   endfunction
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] v);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= v;
      do @(posedge clk_i); while (!wb_ack_o);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_wb.push_back(e);
      wb(1'b0, a, 32'h0);
   endtask
   task automatic mk(input logic [31:0] c);
      for (int k = 0; k < DESC_DW; k++)
         d[k] = $random(seed);
      d[CTRL_DW] = c | {24'h0, d[CTRL_DW][7:0]};
      d[COUNT_DW] = 32'h8;
      d[SRC_LO_DW][1:0] = 2'h0;
   endtask
   task automatic run(input logic [4:0] e, input logic [38:0] b);
      if (!d[CTRL_DW][FLUSH_BIT])
         exp_back.push_back(b);
      desc_i <= d;
      desc_valid_i <= 1'b1;
      do @(posedge clk_i); while (!desc_ready_o);
      desc_valid_i <= 1'b0;
      err_i <= e;
      @(posedge clk_i);
      err_i <= 5'h0;
      do @(negedge clk_i); while (!back_valid_o && !flush_o);
      @(posedge clk_i);
      flush_ack_i <= flush_o;
      @(posedge clk_i);
      flush_ack_i <= 1'b0;
      do @(negedge clk_i); while (back_valid_o || flush_o);
      @(posedge clk_i);
   endtask
   task automatic print_verdict();
      if (n_errors == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      {clk_i, wb_cyc_i, wb_stb_i, wb_we_i, desc_valid_i, pe} = '0;
      {flush_ack_i, slow, err_i, wb_adr_i, wb_dat_i, desc_i} = '0;
      wb_sel_i = 4'hf;
      rst_i = 1'b1;
      seed = 32'hade4;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd(CHAN_OFS, 32'h0);
      wb(1'b1, CHAN_OFS, 32'h1);
      wb(1'b1, IRQEN_OFS, 32'h2);
      rd(8'h10, 32'h0);
      // no address valid, poison and unsupported request together
      mk(32'h0);
      run(5'h11, {2'h0, ERR_POISON, d[CRC_DW]});
      mk(32'h16000000);
      run(5'h0, {2'h0, ERR_NONE, d[CRC_DW]});
      // cross-host source end with its last transfer, then destination end
      mk(32'h86000000);
      exp_rd.push_back({37'h0, d[SRC_LO_DW]});
      exp_wr.push_back({46'h0, d[DST_LO_DW]});
      run(5'h0, {2'h3, ERR_NONE, d[CRC_DW]});
      pe <= 1'b1;
      mk(32'h02000000);
      exp_wr.push_back({46'h0, d[DST_LO_DW]});
      run(5'h0, {2'h1, ERR_NONE, d[CRC_DW]});
      pe <= 1'b0;
      wb(1'b1, MODE_OFS, 32'h3);
      slow <= 1'b1;
      // interrupt, tph, both valid, wide, both domains, checksum
      mk(32'h67e00000);
      exp_rd.push_back({1'b1, d[DOM_DW][11:8], d[SRC_HI_DW], d[SRC_LO_DW]});
      exp_wr.push_back({1'b1, d[CTRL_DW][7:0], 1'b1, d[DOM_DW][3:0],
                        d[DST_HI_DW], d[DST_LO_DW]});
      run(5'h0, {2'h1, ERR_NONE, crc_of(2)});
      rd(CHAN_OFS, 32'h80000001);
      `CHK("intx", 1'b0, intx_o)
      wb(1'b1, IRQEN_OFS, 32'h1);
      `CHK("intx", 1'b1, intx_o)
      wb(1'b1, CHAN_OFS, 32'h80000001);
      rd(CHAN_OFS, 32'h1);
      mk(32'h06000000);
      exp_rd.push_back({5'h0, 32'h0, d[SRC_LO_DW]});
      exp_wr.push_back({46'h0, d[DST_LO_DW]});
      run(5'h0, {2'h1, ERR_NONE, d[CRC_DW]});
      mk(32'h08000000);
      run(5'h0, 39'h0);
      rd(CHAN_OFS, 32'h0);
      rd(MODE_OFS, 32'h0);
      `CHK("msi", 1, n_msi)
      `CHK("left", 0, exp_back.size() + exp_rd.size() + exp_wr.size())
      print_verdict();
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      n_errors++;
      print_verdict();
   end
endmodule
